// >>> verilog/acpr_ctrl.v
// Conversion, power-down and reference control of a SAR converter
// Functional notes
// - Falling start edge launches a conversion
// - Running conversion ignores starts and power-down
// - Chip select and read never gate starts
// - Both selects low: bandgap, buffer, sensor on
// - Ref off only: bandgap down, buffer on
// - Both selects high: bandgap and buffer down
// - Temperature sensor only in internal mode
// - Power-down waits for conversion, bus stays
// - Register power-down overrides the pin
// - Impulse mode: low current after conversion
// - Digital interface stays active in acquisition
// - Reset rise aborts, fall clears configuration
// - Busy high while converting, low when done
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "acpr_regs.vh"
module acpr_ctrl #(
   parameter CONV_CYC = `ACPR_CONV_CYC,
   parameter CW = 8
) (
   input wire core_clk,
   input wire resetn,
   input wire conversion_start_n,
   input wire power_down_input,
   input wire internal_ref_off,
   input wire ref_buffer_off,
   input wire dev_reset,
   input wire cs_n,
   input wire rd_n,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg busy,
   output reg sample_hold,
   output reg bandgap_en,
   output reg ref_buffer_en,
   output reg temp_sensor_en,
   output reg power_down_active,
   output reg low_current,
   output reg data_bus_float,
   output reg data_clear
);
   localparam ST_IDLE = 2'd0;
   localparam ST_CONV = 2'd1;
   localparam ST_RST = 2'd2;

   // Last count value, cut to the counter width on purpose
   localparam integer CONV_LAST_I = CONV_CYC - 1;
   localparam [CW-1:0] CONV_LAST = CONV_LAST_I[CW-1:0];

   wire [4:0] pins_s;
   wire start_s;
   wire pd_pin_s;
   wire refoff_s;
   wire bufoff_s;
   wire rst_s;

   reg start_prev_q;
   reg rst_prev_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [CW-1:0] cnt_q;
   reg [CW-1:0] cnt_d;
   reg [7:0] cfg_q;
   reg [7:0] conv_count_q;
   reg abort_seen_q;
   reg pd_eff_q;

   // All pins are asynchronous to core_clk; start idles high
   acpr_sync #(
      .W(5),
      .INIT(5'h01)
   ) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in({dev_reset, ref_buffer_off, internal_ref_off,
                 power_down_input, conversion_start_n}),
      .sync_out(pins_s)
   );

   assign start_s = pins_s[0];
   assign pd_pin_s = pins_s[1];
   assign refoff_s = pins_s[2];
   assign bufoff_s = pins_s[3];
   assign rst_s = pins_s[4];

   // Edge detection on synchronised copies only
   wire start_fall = start_prev_q & ~start_s;
   wire rst_rise = ~rst_prev_q & rst_s;
   wire rst_fall = rst_prev_q & ~rst_s;
   wire conv_done = (state_q == ST_CONV) && (cnt_q == CONV_LAST);

   // Requested power-down source
   wire pd_req = cfg_q[`ACPR_CFG_SW_EN] ? cfg_q[`ACPR_CFG_PD]
                                        : pd_pin_s;

   // Write strobe aimed at one register index
   function addr_hit;
      input strobe;
      input [3:0] addr;
      input [3:0] want;
      begin
         addr_hit = strobe && (addr == want);
      end
   endfunction

   // Register write decodes, shared by the writers below
   wire cfg_wr = addr_hit(reg_wr, reg_addr, `ACPR_ADDR_CFG);
   wire stat_wr = addr_hit(reg_wr, reg_addr, `ACPR_ADDR_STATUS);

   // Reference mode from the synchronised selects
   wire mode_int = ~refoff_s & ~bufoff_s;
   wire bg_on = ~refoff_s;
   wire buf_on = ~bufoff_s;

   // Status word as software sees it; bit 7 reads zero
   wire [7:0] status_word = {1'b0, abort_seen_q, temp_sensor_en,
      ref_buffer_en, bandgap_en, low_current, power_down_active, busy};

   always @(posedge core_clk) begin
      if (!resetn) begin
         start_prev_q <= 1'b1;
         rst_prev_q <= 1'b0;
      end else begin
         start_prev_q <= start_s;
         rst_prev_q <= rst_s;
      end
   end

   // Conversion sequencer; cs_n and rd_n deliberately not consulted
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE: begin
            // Power-down blocks new starts only while idle
            if (rst_rise) begin
               state_d = ST_RST;
            end else if (start_fall && !pd_eff_q) begin
               state_d = ST_CONV;
               cnt_d = {CW{1'b0}};
            end
         end
         ST_CONV: begin
            // Further start edges and power-down are ignored here
            if (rst_rise) begin
               state_d = ST_RST;
            end else if (conv_done) begin
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         ST_RST: begin
            if (rst_fall) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         cnt_q <= {CW{1'b0}};
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Effective power-down only updates outside a conversion
   always @(posedge core_clk) begin
      if (!resetn) begin
         pd_eff_q <= 1'b0;
      end else if (state_d != ST_CONV) begin
         pd_eff_q <= pd_req;
      end
   end

   // Configuration register; device reset clears it on falling edge
   always @(posedge core_clk) begin
      if (!resetn) begin
         cfg_q <= `ACPR_CFG_RST;
      end else if (rst_fall) begin
         cfg_q <= `ACPR_CFG_RST;
      end else if (cfg_wr) begin
         cfg_q <= {5'h00, reg_wdata[2:0]};
      end
   end

   // Completed conversion counter and sticky abort flag
   always @(posedge core_clk) begin
      if (!resetn) begin
         conv_count_q <= 8'h00;
         abort_seen_q <= 1'b0;
      end else begin
         if (conv_done && !rst_rise) begin
            conv_count_q <= conv_count_q + 8'h01;
         end
         // Set wins over a clear in the same cycle
         if (state_q == ST_CONV && rst_rise) begin
            abort_seen_q <= 1'b1;
         end else if (stat_wr && reg_wdata[`ACPR_ST_ABORT]) begin
            abort_seen_q <= 1'b0;
         end
      end
   end

   // Register read port; answers even while powered down
   always @(posedge core_clk) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ACPR_ADDR_CFG: reg_rdata <= cfg_q;
            `ACPR_ADDR_STATUS: reg_rdata <= status_word;
            `ACPR_ADDR_COUNT: reg_rdata <= conv_count_q;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Busy follows the next state, so it rises with the start
   always @(posedge core_clk) begin
      if (!resetn) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_d == ST_CONV);
      end
   end

   // Sampling instant is the start edge itself
   always @(posedge core_clk) begin
      if (!resetn) begin
         sample_hold <= 1'b0;
      end else begin
         sample_hold <= (state_q == ST_IDLE) && (state_d == ST_CONV);
      end
   end

   // Power-down shows only between conversions
   always @(posedge core_clk) begin
      if (!resetn) begin
         power_down_active <= 1'b0;
      end else begin
         power_down_active <= pd_eff_q && (state_d != ST_CONV);
      end
   end

   // Impulse mode drops current whenever not converting;
   // the register port keeps running meanwhile
   always @(posedge core_clk) begin
      if (!resetn) begin
         low_current <= 1'b0;
      end else begin
         low_current <= cfg_q[`ACPR_CFG_IMPULSE] &&
                        (state_d != ST_CONV);
      end
   end

   // Bandgap on unless its select is high or powered down
   always @(posedge core_clk) begin
      if (!resetn) begin
         bandgap_en <= 1'b1;
      end else begin
         bandgap_en <= bg_on & ~pd_eff_q;
      end
   end

   // Buffer on unless its select is high or powered down
   always @(posedge core_clk) begin
      if (!resetn) begin
         ref_buffer_en <= 1'b1;
      end else begin
         ref_buffer_en <= buf_on & ~pd_eff_q;
      end
   end

   // Sensor needs the full internal reference path
   always @(posedge core_clk) begin
      if (!resetn) begin
         temp_sensor_en <= 1'b1;
      end else begin
         temp_sensor_en <= mode_int & ~pd_eff_q;
      end
   end

   // Data bus floats while device reset is high
   always @(posedge core_clk) begin
      if (!resetn) begin
         data_bus_float <= 1'b0;
      end else begin
         data_bus_float <= (state_d == ST_RST);
      end
   end

   // One-cycle clear pulse on the reset fall
   always @(posedge core_clk) begin
      if (!resetn) begin
         data_clear <= 1'b0;
      end else begin
         data_clear <= rst_fall;
      end
   end
endmodule

// >>> pkg/acpr_regs.vh
// Constants for the converter power and reference control block
`ifndef ACPR_REGS_VH
`define ACPR_REGS_VH

// Register indices on the plain register port
`define ACPR_ADDR_CFG 4'h0
`define ACPR_ADDR_STATUS 4'h1
`define ACPR_ADDR_COUNT 4'h2

// Configuration register field positions and reset value
`define ACPR_CFG_SW_EN 0
`define ACPR_CFG_PD 1
`define ACPR_CFG_IMPULSE 2
`define ACPR_CFG_RST 8'h00

// Status register field positions
`define ACPR_ST_BUSY 0
`define ACPR_ST_PD 1
`define ACPR_ST_LOWI 2
`define ACPR_ST_BG 3
`define ACPR_ST_BUF 4
`define ACPR_ST_TEMP 5
`define ACPR_ST_ABORT 6

// Conversion time in ns and derived cycles at 20 MHz (50 ns period)
`define ACPR_CONV_NS 700
`define ACPR_CLK_NS 50
`define ACPR_CONV_CYC ((`ACPR_CONV_NS + `ACPR_CLK_NS - 1) / `ACPR_CLK_NS)

`endif

// >>> verilog/acpr_sync.v
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module acpr_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input wire core_clk,
   input wire resetn,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge core_clk) begin
      if (!resetn) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// >>> dv/acpr_ctrl_sva.sv
// Assertion checker for the converter control block
`timescale 1ns/1ps
module acpr_ctrl_sva #(
   parameter CONV_CYC = 14
) (
   input logic core_clk,
   input logic resetn,
   input logic conversion_start_n,
   input logic internal_ref_off,
   input logic ref_buffer_off,
   input logic dev_reset,
   input logic busy,
   input logic sample_hold,
   input logic bandgap_en,
   input logic ref_buffer_en,
   input logic temp_sensor_en,
   input logic power_down_active,
   input logic low_current,
   input logic data_bus_float,
   input logic data_clear
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   logic [7:0] cnt_q;
   // Busy run length, cleared whenever busy drops
   always @(posedge core_clk) begin
      if (!resetn || !busy)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_q + 8'h01;
   end
   // Pins pass two sync flops, so allow a few edges of lag
   a_start_busy: assert property ($fell(conversion_start_n) && !busy
      && !power_down_active && !dev_reset |-> ##[1:4] busy)
      else $error("start edge did not raise busy");
   a_sh_busy: assert property ($rose(busy) |-> sample_hold)
      else $error("no sample pulse at busy rise");
   a_sh_pulse: assert property (sample_hold |=> !sample_hold)
      else $error("sample pulse too long");
   a_busy_len: assert property ($fell(busy) && !data_bus_float
      |-> cnt_q == CONV_CYC)
      else $error("busy length wrong");
   a_pd_idle: assert property ($rose(power_down_active) |-> !busy)
      else $error("power-down entered mid conversion");
   a_ref_int: assert property ((!internal_ref_off && !ref_buffer_off
      && !power_down_active)[*4]
      |-> bandgap_en && ref_buffer_en && temp_sensor_en)
      else $error("internal mode enables wrong");
   a_ref_buf: assert property ((internal_ref_off && !ref_buffer_off
      && !power_down_active)[*4]
      |-> !bandgap_en && ref_buffer_en && !temp_sensor_en)
      else $error("buffered mode enables wrong");
   a_ref_ext: assert property ((internal_ref_off && ref_buffer_off)[*4]
      |-> !bandgap_en && !ref_buffer_en)
      else $error("external mode enables wrong");
   a_temp_int: assert property (temp_sensor_en
      |-> bandgap_en && ref_buffer_en)
      else $error("sensor on outside internal mode");
   a_lowi_idle: assert property (low_current |-> !busy)
      else $error("low current while converting");
   a_float_rst: assert property (dev_reset[*4]
      |-> data_bus_float && !busy)
      else $error("reset did not abort");
   a_clr_pulse: assert property ($fell(data_bus_float)
      |-> ##[0:1] data_clear)
      else $error("no clear after reset fall");
   c_conv: cover property ($fell(busy));
   c_abort: cover property (dev_reset && busy);
   c_lowi: cover property ($rose(low_current));
endmodule
bind acpr_ctrl acpr_ctrl_sva #(.CONV_CYC(CONV_CYC)) u_sva (
   .core_clk(core_clk), .resetn(resetn),
   .conversion_start_n(conversion_start_n),
   .internal_ref_off(internal_ref_off), .ref_buffer_off(ref_buffer_off),
   .dev_reset(dev_reset), .busy(busy), .sample_hold(sample_hold),
   .bandgap_en(bandgap_en), .ref_buffer_en(ref_buffer_en),
   .temp_sensor_en(temp_sensor_en), .power_down_active(power_down_active),
   .low_current(low_current), .data_bus_float(data_bus_float),
   .data_clear(data_clear));

// >>> dv/acpr_host.sv
// Host model driving the start, mode and reset pins
`timescale 1ns/1ps
module acpr_host (
   input wire logic core_clk,
   output logic conversion_start_n,
   output logic power_down_input,
   output logic internal_ref_off,
   output logic ref_buffer_off,
   output logic dev_reset
);
   // Idle levels: no start, internal reference selected
   initial begin
      conversion_start_n = 1'b1;
      power_down_input = 1'b0;
      internal_ref_off = 1'b0;
      ref_buffer_off = 1'b0;
      dev_reset = 1'b0;
   end
   // Each pin moves just after a rising edge
   task automatic set_start(input logic v);
      @(posedge core_clk);
      conversion_start_n <= v;
   endtask
   task automatic set_pd(input logic v);
      @(posedge core_clk);
      power_down_input <= v;
   endtask
   task automatic set_ref(input logic a, input logic b);
      @(posedge core_clk);
      internal_ref_off <= a;
      ref_buffer_off <= b;
   endtask
   task automatic set_reset(input logic v);
      @(posedge core_clk);
      dev_reset <= v;
   endtask
endmodule

// >>> dv/acpr_ctrl_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module acpr_ctrl_tb_top;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic cs_n = 1'b1;
   logic rd_n = 1'b1;
   wire [7:0] reg_rdata;
   wire conversion_start_n, power_down_input, internal_ref_off;
   wire ref_buffer_off, dev_reset, busy, sample_hold, bandgap_en;
   wire ref_buffer_en, temp_sensor_en, power_down_active, low_current;
   wire data_bus_float, data_clear;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [1:0] refs [3] = '{2'b10, 2'b11, 2'b00};
   logic [7:0] stat [3] = '{8'h10, 8'h00, 8'h38};
   always #25 core_clk = ~core_clk;
   acpr_host host (.core_clk(core_clk),
      .conversion_start_n(conversion_start_n),
      .power_down_input(power_down_input),
      .internal_ref_off(internal_ref_off), .ref_buffer_off(ref_buffer_off),
      .dev_reset(dev_reset));
   // Chip select and read driven both ways: starts must ignore them
   acpr_ctrl #(.CONV_CYC(10)) uut (.core_clk(core_clk), .resetn(resetn),
      .conversion_start_n(conversion_start_n),
      .power_down_input(power_down_input),
      .internal_ref_off(internal_ref_off), .ref_buffer_off(ref_buffer_off),
      .dev_reset(dev_reset), .cs_n(cs_n), .rd_n(rd_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .busy(busy), .sample_hold(sample_hold),
      .bandgap_en(bandgap_en), .ref_buffer_en(ref_buffer_en),
      .temp_sensor_en(temp_sensor_en), .power_down_active(power_down_active),
      .low_current(low_current), .data_bus_float(data_bus_float),
      .data_clear(data_clear));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("errors=%0d checks=%0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Waits end just past an edge so outputs have settled
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      while (busy !== v && n < 40) begin
         idle(1);
         n++;
      end
      chk({7'h00, busy}, {7'h00, v});
   endtask
   // Hang guard, far above the roughly 150 cycles needed
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      idle(3);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h38);
      rd(4'hf, 8'h00);
      host.set_start(1'b0);
      wait_busy(1'b1);
      chk({7'h00, sample_hold}, 8'h01);
      host.set_start(1'b1);
      host.set_start(1'b0);
      host.set_pd(1'b1);
      wait_busy(1'b0);
      idle(4);
      chk({7'h00, power_down_active}, 8'h01);
      rd(4'h2, 8'h01);
      host.set_start(1'b1);
      host.set_pd(1'b0);
      idle(5);
      rd(4'h1, 8'h38);
      foreach (refs[i]) begin
         host.set_ref(refs[i][1], refs[i][0]);
         idle(5);
         rd(4'h1, stat[i]);
      end
      host.set_pd(1'b1);
      wr(4'h0, 8'h01);
      idle(5);
      rd(4'h1, 8'h38);
      wr(4'h0, 8'h03);
      idle(2);
      rd(4'h1, 8'h02);
      wr(4'h0, 8'h05);
      idle(2);
      rd(4'h1, 8'h3c);
      @(posedge core_clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      host.set_start(1'b0);
      wait_busy(1'b1);
      idle(1);
      chk({7'h00, low_current}, 8'h00);
      wait_busy(1'b0);
      idle(2);
      chk({7'h00, low_current}, 8'h01);
      rd(4'h2, 8'h02);
      host.set_pd(1'b0);
      host.set_start(1'b1);
      host.set_start(1'b0);
      wait_busy(1'b1);
      host.set_reset(1'b1);
      idle(5);
      chk({6'h00, data_bus_float, busy}, 8'h02);
      host.set_reset(1'b0);
      idle(3);
      chk({7'h00, data_clear}, 8'h01);
      idle(2);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h78);
      wr(4'h1, 8'h40);
      rd(4'h1, 8'h38);
      final_report();
   end
endmodule
